/* File: hw/glue_pkg.sv */
// Constants shared by the peripheral identifier, interrupt and clock glue.
package glue_pkg;

	// Peripheral address range and slot geometry
	localparam logic [31:0] PERIPH_BASE = 32'hFFFA_0000;
	localparam logic [31:0] PERIPH_LAST = 32'hFFFC_FFFF;
	localparam int          SLOT_SHIFT  = 14;
	localparam int          SLOT_BITS   = 4;

	// Peripheral identifiers
	localparam int ID_FAST        = 0;
	localparam int ID_SYS         = 1;
	localparam int ID_IO_FIRST    = 2;
	localparam int ID_CONV        = 5;
	localparam int ID_RSV_LO      = 15;
	localparam int ID_RSV_HI      = 16;
	localparam int ID_USB_HOST    = 20;
	localparam int ID_LAST_PERIPH = 28;
	localparam int ID_EXT_FIRST   = 29;
	localparam int ID_EXT_LAST    = 31;
	localparam int EXT_COUNT      = 3;
	localparam int SYS_SRC_COUNT  = 8;

	// Clock gate and interrupt masks: ignored ids, reserved ids, and reset state
	localparam logic [31:0] CLK_IGNORE_MASK   = 32'hE010_0023;
	localparam logic [31:0] CLK_RESERVED_MASK = 32'h0001_8000;
	localparam logic [31:0] CLK_WRITABLE_MASK = 32'h1FEE_7FDC;
	localparam logic [31:0] CLK_RESET         = 32'h0000_0002;
	localparam logic [31:0] CLK_FIXED_MASK    = 32'hE011_8003;
	localparam logic [31:0] PERIPH_IRQ_MASK   = 32'h1FFE_7FFC;

	// Register byte offsets
	localparam logic [7:0] REG_CHIP_ID    = 8'h00;
	localparam logic [7:0] REG_CLK_SET    = 8'h04;
	localparam logic [7:0] REG_CLK_CLEAR  = 8'h08;
	localparam logic [7:0] REG_CLK_STATUS = 8'h0C;
	localparam logic [7:0] REG_MODE       = 8'h10;
	localparam logic [7:0] REG_EVT_STATUS = 8'h14;
	localparam logic [7:0] REG_EVT_CLEAR  = 8'h18;
	localparam logic [7:0] REG_EVT_ENABLE = 8'h1C;
	localparam logic [7:0] IO_BASE        = 8'h20;
	localparam logic [7:0] IO_END         = 8'h50;
	localparam logic [3:0] IO_SEL_OFS     = 4'h0;
	localparam logic [3:0] IO_AB_OFS      = 4'h4;
	localparam logic [3:0] IO_PULL_OFS    = 4'h8;

	// Mode bits
	localparam int          MODE_SLEEP = 0;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;

	// Event bits
	localparam int         EVT_WIDTH       = 3;
	localparam int         EVT_CONV_START  = 0;
	localparam int         EVT_CONV_STOP   = 1;
	localparam int         EVT_DECODE_MISS = 2;
	localparam logic [2:0] EVT_RESET       = 3'h0;

	// Chip identification: base value is arbitrary, low bits carry the memory variant
	localparam logic [31:0] CHIP_ID_BASE   = 32'h5A5A_0000;
	localparam logic [1:0]  MEM_VARIANT    = 2'h2;

	// I/O controllers and their reset state
	localparam int          IO_COUNT        = 3;
	localparam int          IO_LINES        = 32;
	localparam logic [31:0] IO_RESET_PULLUP = 32'hFFFF_FFFF;
	localparam logic [31:0] IO_RESET_AB     = 32'h0000_0000;
	localparam logic [IO_COUNT-1:0][31:0] IO_RESET_PERIPH = {
		32'h0000_00FF, 32'h0000_0000, 32'h0000_0000
	};

endpackage

/* File: hw/sync_bank.sv */
// Two flip-flop synchroniser bank for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module sync_bank
	import glue_pkg::*;
#(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_reg;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end

endmodule
`default_nettype wire

/* File: hw/slot_decoder.sv */
// Registered decoder from a system address to a peripheral slot index.
`timescale 1ns/1ps
`default_nettype none
module slot_decoder
	import glue_pkg::*;
(
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	// Address in
	input  wire logic [31:0]          sys_addr,
	input  wire logic                 sys_addr_valid,
	// Decode out
	output logic                      slot_hit,
	output logic      [SLOT_BITS-1:0] slot_index,
	output logic                      slot_miss
);

	wire        in_range = (sys_addr >= PERIPH_BASE) && (sys_addr <= PERIPH_LAST);
	wire [31:0] rel_addr = sys_addr - PERIPH_BASE;
	wire [SLOT_BITS-1:0] rel_slot = rel_addr[SLOT_SHIFT+SLOT_BITS-1:SLOT_SHIFT];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slot_hit   <= 1'b0;
			slot_index <= '0;
			slot_miss  <= 1'b0;
		end else begin
			slot_hit   <= sys_addr_valid & in_range;
			slot_index <= in_range ? rel_slot : '0;
			slot_miss  <= sys_addr_valid & ~in_range;
		end
	end

endmodule
`default_nettype wire

/* File: hw/periph_glue.sv */
// Peripheral identifier glue: slot decode, interrupt routing, clock gates, I/O reset state.
//
// Notes on behaviour
// - Decode user peripheral addresses from FFFA0000 through FFFCFFFF inclusive.
// - Each user peripheral owns one contiguous 16 KB window.
// - One identifier picks both the interrupt source bit and clock-gate bit.
// - Identifiers 2 to 28 are peripherals; 15 and 16 stay reserved.
// - Fast input is source 0; external inputs are 29 to 31, no clock.
// - Clock writes ignored for ids 0, 1, 5, 20, 29, 30, 31.
// - Converter clock starts on first conversion; in sleep, stops after each.
// - Source 1 is the OR of the eight system unit interrupts.
// - System unit clocks always run; id 1 is interrupt only.
// - Three I/O controllers, thirty-two lines each.
// - Each non-GPIO line takes exactly one function, A or B.
// - GPIO-reset lines leave reset as inputs, pull-up on, select bit 0.
// - Peripheral-reset lines leave reset assigned, pull-up on, select bit 1.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module periph_glue
	import glue_pkg::*;
(
	// Clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         rst,
	// Wishbone slave
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [7:0]                   wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	// Slot decode
	input  wire logic [31:0]                  sys_addr,
	input  wire logic                         sys_addr_valid,
	output logic                              slot_hit,
	output logic      [SLOT_BITS-1:0]         slot_index,
	// Interrupt inputs
	input  wire logic                         fast_interrupt_input,
	input  wire logic [EXT_COUNT-1:0]         external_interrupt_inputs,
	input  wire logic [ID_LAST_PERIPH:ID_IO_FIRST] periph_irq,
	input  wire logic [SYS_SRC_COUNT-1:0]     system_unit_irqs,
	// Converter activity
	input  wire logic                         conv_start,
	input  wire logic                         conv_done,
	// Toward the vectored_irq_controller and power_clock_manager
	output logic      [31:0]                  irq_source,
	output logic      [31:0]                  periph_clk_en,
	// I/O controllers
	output logic      [IO_COUNT-1:0][31:0]    peripheral_select_status,
	output logic      [IO_COUNT-1:0][31:0]    io_func_b_sel,
	output logic      [IO_COUNT-1:0][31:0]    io_pullup_en,
	// Block interrupt
	output logic                              evt_irq
);

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [31:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	localparam logic [31:0] CHIP_ID = CHIP_ID_BASE | {30'h0, MEM_VARIANT};

	logic [31:0]          mode_reg;
	logic [EVT_WIDTH-1:0] evt_status_reg;
	logic [EVT_WIDTH-1:0] evt_enable_reg;
	logic [31:0]          rdata;

	// Bus decode
	wire        req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land on the edge where ack is seen, while the master still holds data
	wire        wr        = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	wire [31:0] bmask     = lane_mask(wb_sel_i);
	wire [31:0] wdata_m   = wb_dat_i & bmask;
	wire        hit_set   = wr && (wb_adr_i == REG_CLK_SET);
	wire        hit_clr   = wr && (wb_adr_i == REG_CLK_CLEAR);
	wire        hit_mode  = wr && (wb_adr_i == REG_MODE);
	wire        hit_eclr  = wr && (wb_adr_i == REG_EVT_CLEAR);
	wire        hit_een   = wr && (wb_adr_i == REG_EVT_ENABLE);
	wire [7:0]  io_rel    = wb_adr_i - IO_BASE;
	wire        io_range  = (wb_adr_i >= IO_BASE) && (wb_adr_i < IO_END);
	wire [1:0]  io_idx    = io_rel[5:4];
	wire [3:0]  io_ofs    = io_rel[3:0];
	wire        io_known  = (io_ofs == IO_SEL_OFS) || (io_ofs == IO_AB_OFS)
		|| (io_ofs == IO_PULL_OFS);
	wire        io_hit    = io_range && io_known;

	// Pin synchronisation and slot decode
	logic [EXT_COUNT:0] pins_sync;
	logic               slot_miss;

	sync_bank #(
		.WIDTH (EXT_COUNT + 1)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in ({external_interrupt_inputs, fast_interrupt_input}),
		.sync_out (pins_sync)
	);

	slot_decoder u_decode (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.sys_addr       (sys_addr),
		.sys_addr_valid (sys_addr_valid),
		.slot_hit       (slot_hit),
		.slot_index     (slot_index),
		.slot_miss      (slot_miss)
	);

	// Interrupt source assembly, one bit per identifier
	wire [31:0] periph_bits = {3'h0, periph_irq, 2'h0} & PERIPH_IRQ_MASK;
	wire [31:0] irq_next    = periph_bits
		| {pins_sync[EXT_COUNT:1], 29'h0}
		| {30'h0, |system_unit_irqs, 1'b0}
		| {31'h0, pins_sync[0]};

	// Clock gates; fixed bits never follow software
	wire        sleep     = mode_reg[MODE_SLEEP];
	wire        conv_on   = periph_clk_en[ID_CONV];
	wire [31:0] set_bits  = hit_set ? wdata_m : 32'h0000_0000;
	wire [31:0] clr_bits  = hit_clr ? wdata_m : 32'h0000_0000;
	wire [31:0] clk_sw    = (((periph_clk_en | set_bits) & ~clr_bits) & CLK_WRITABLE_MASK)
		| CLK_RESET;
	// Start beats stop when both land together
	wire        conv_next = conv_start | (conv_on & ~(sleep & conv_done));
	wire [31:0] clk_next  = merge(clk_sw, {26'h0, conv_next, 5'h0}, 32'h0000_0020);

	// Events; a set in the clearing cycle survives
	wire                 conv_up  = conv_start & ~conv_on;
	wire                 conv_off = sleep & conv_done & conv_on & ~conv_start;
	wire [EVT_WIDTH-1:0] evt_set  = {slot_miss, conv_off, conv_up};
	wire [EVT_WIDTH-1:0] evt_clr  = hit_eclr ? wdata_m[EVT_WIDTH-1:0] : '0;
	wire [EVT_WIDTH-1:0] evt_next = (evt_status_reg & ~evt_clr) | evt_set;
	wire [31:0]          een_all  = merge({29'h0, evt_enable_reg}, wb_dat_i, bmask);

	// Read mux
	always_comb begin
		rdata = 32'h0000_0000;
		if (io_hit) begin
			case (io_ofs)
				IO_SEL_OFS: rdata = peripheral_select_status[io_idx];
				IO_AB_OFS: rdata = io_func_b_sel[io_idx];
				IO_PULL_OFS: rdata = io_pullup_en[io_idx];
				default: rdata = 32'h0000_0000;
			endcase
		end else begin
			case (wb_adr_i)
				REG_CHIP_ID: rdata = CHIP_ID;
				REG_CLK_STATUS: rdata = periph_clk_en;
				REG_MODE: rdata = mode_reg;
				REG_EVT_STATUS: rdata = {29'h0, evt_status_reg};
				REG_EVT_ENABLE: rdata = {29'h0, evt_enable_reg};
				default: rdata = 32'h0000_0000;
			endcase
		end
	end

	// Bus handshake: one wait state, unmapped reads give zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= (req && !wb_we_i) ? rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_source    <= 32'h0000_0000;
			periph_clk_en <= CLK_RESET;
		end else begin
			irq_source    <= irq_next;
			periph_clk_en <= clk_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_reg       <= MODE_RESET;
			evt_status_reg <= EVT_RESET;
			evt_enable_reg <= EVT_RESET;
			evt_irq        <= 1'b0;
		end else begin
			if (hit_mode)
				mode_reg <= merge(mode_reg, wb_dat_i, bmask & 32'h0000_0001);
			if (hit_een)
				evt_enable_reg <= een_all[EVT_WIDTH-1:0];
			evt_status_reg <= evt_next;
			evt_irq        <= |(evt_status_reg & evt_enable_reg);
		end
	end

	// I/O controllers; function select bit picks B when set, A when clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			peripheral_select_status <= IO_RESET_PERIPH;
			io_func_b_sel            <= {IO_COUNT{IO_RESET_AB}};
			io_pullup_en             <= {IO_COUNT{IO_RESET_PULLUP}};
		end else begin
			for (int i = 0; i < IO_COUNT; i++) begin
				if (wr && io_hit && (io_idx == i[1:0])) begin
					if (io_ofs == IO_SEL_OFS)
						peripheral_select_status[i] <=
							merge(peripheral_select_status[i], wb_dat_i, bmask);
					if (io_ofs == IO_AB_OFS)
						io_func_b_sel[i] <= merge(io_func_b_sel[i], wb_dat_i, bmask);
					if (io_ofs == IO_PULL_OFS)
						io_pullup_en[i] <= merge(io_pullup_en[i], wb_dat_i, bmask);
				end
			end
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence fast_held;
		fast_interrupt_input [*4];
	endsequence

	sequence ext_high_held;
		external_interrupt_inputs[0] [*4];
	endsequence

	fixed_clocks_a: assert property ((periph_clk_en & CLK_FIXED_MASK) == CLK_RESET)
		else $error("fixed clock gate bits changed");

	sys_clock_on_a: assert property (periph_clk_en[ID_SYS] && !irq_source[ID_RSV_LO])
		else $error("system clock gate dropped");

	conv_start_a: assert property (conv_start |=> periph_clk_en[ID_CONV])
		else $error("converter clock did not start");

	conv_stop_a: assert property (sleep && conv_done && !conv_start
		|=> !periph_clk_en[ID_CONV])
		else $error("converter clock not stopped in sleep");

	conv_hold_a: assert property (!sleep && periph_clk_en[ID_CONV] && !hit_clr
		|=> periph_clk_en[ID_CONV])
		else $error("converter clock stopped outside sleep");

	sys_irq_or_a: assert property (1'b1 |=> irq_source[ID_SYS] == $past(|system_unit_irqs))
		else $error("source 1 is not the system OR");

	fast_route_a: assert property (fast_held |-> irq_source[ID_FAST])
		else $error("fast input not on source 0");

	ext_route_a: assert property (ext_high_held |-> irq_source[ID_EXT_FIRST])
		else $error("external input not on source 29");

	reserved_ids_a: assert property (irq_source[ID_RSV_HI:ID_RSV_LO] == 2'b00
		&& periph_clk_en[ID_RSV_HI:ID_RSV_LO] == 2'b00)
		else $error("reserved identifier active");

	slot_decode_a: assert property (sys_addr_valid && sys_addr >= PERIPH_BASE
		&& sys_addr <= PERIPH_LAST |=> slot_hit
		&& slot_index == $past(sys_addr[SLOT_SHIFT+SLOT_BITS-1:SLOT_SHIFT]) - 4'h8)
		else $error("slot decode wrong");

	slot_range_a: assert property (sys_addr_valid
		&& (sys_addr < PERIPH_BASE || sys_addr > PERIPH_LAST)
		|=> !slot_hit)
		else $error("decode outside peripheral range");

	io_reset_a: assert property ($past(rst) |-> peripheral_select_status == IO_RESET_PERIPH
		&& io_pullup_en == {IO_COUNT{IO_RESET_PULLUP}})
		else $error("I/O reset state wrong");

	chip_id_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == REG_CHIP_ID
		|-> wb_dat_o == CHIP_ID)
		else $error("chip id read wrong");

	bus_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle after request");

	read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");

	miss_event_a: assert property (slot_miss |=> evt_status_reg[EVT_DECODE_MISS])
		else $error("decode miss event not recorded");

	irq_level_a: assert property (1'b1 |=> evt_irq == $past(|(evt_status_reg & evt_enable_reg)))
		else $error("block interrupt level wrong");

	clk_set_a: assert property (hit_set && wdata_m[ID_IO_FIRST] |=> periph_clk_en[ID_IO_FIRST])
		else $error("clock set write lost");

	clk_clear_a: assert property (hit_clr && wdata_m[ID_IO_FIRST] |=> !periph_clk_en[ID_IO_FIRST])
		else $error("clock clear write lost");

	periph_route_a: assert property (periph_irq[ID_IO_FIRST] |=> irq_source[ID_IO_FIRST])
		else $error("peripheral interrupt not on its source");

	func_write_a: assert property (wr && io_hit && io_ofs == IO_AB_OFS && io_idx == 2'h0
		&& bmask == 32'hFFFF_FFFF |=> io_func_b_sel[0] == $past(wb_dat_i))
		else $error("function select write lost");

endmodule
`default_nettype wire

/* File: verification/irq_clock_partner.sv */
// Model of the interrupt controller and clock manager fed by the glue.
`timescale 1ns/1ps
`default_nettype none
module irq_clock_partner (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// From the glue
	input  wire logic [31:0] irq_source,
	input  wire logic [31:0] periph_clk_en,
	// Sticky record of what was ever seen
	output logic      [31:0] pending_seen,
	output logic      [31:0] clocks_seen
);
	// Sticky, like a pending register, so short pulses are not lost
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pending_seen <= 32'h0000_0000;
			clocks_seen  <= 32'h0000_0000;
		end else begin
			pending_seen <= pending_seen | irq_source;
			clocks_seen  <= clocks_seen | periph_clk_en;
		end
	end
endmodule
`default_nettype wire

/* File: verification/peripheral_id_irq_clock_map_bench.sv */
// Self-checking bench for the peripheral identifier glue.
`timescale 1ns/1ps
`default_nettype none
module peripheral_id_irq_clock_map_bench
	import glue_pkg::*;
;
	logic ref_clk, rst, cyc, stb, we, ack, fast, sua, hit, conv_s, conv_d, eirq;
	logic [7:0] adr;
	logic [3:0] sel, sidx;
	logic [31:0] dat_i, dat_o, saddr, src, clk_en, pend, clks, rd;
	logic [2:0] ext;
	logic [28:2] pirq;
	logic [7:0] sysirq;
	logic [IO_COUNT-1:0][31:0] psel, bsel, pull;
	int errors, checks;

	periph_glue DUT (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .sys_addr(saddr), .sys_addr_valid(sua), .slot_hit(hit),
		.slot_index(sidx), .fast_interrupt_input(fast), .external_interrupt_inputs(ext),
		.periph_irq(pirq), .system_unit_irqs(sysirq), .conv_start(conv_s),
		.conv_done(conv_d), .irq_source(src), .periph_clk_en(clk_en),
		.peripheral_select_status(psel), .io_func_b_sel(bsel), .io_pullup_en(pull),
		.evt_irq(eirq));
	irq_clock_partner partner (.ref_clk(ref_clk), .rst(rst), .irq_source(src),
		.periph_clk_en(clk_en), .pending_seen(pend), .clocks_seen(clks));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// One classic cycle; ack seen high at an edge ends the request there
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= d;
		sel <= 4'hF;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50) begin
			errors++;
			end_sim();
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		cmp(rd, exp);
	endtask

	task automatic slot(input logic [31:0] a, input logic h, input logic [3:0] i);
		@(posedge ref_clk);
		saddr <= a;
		sua <= 1'b1;
		tick(1);
		cmp({27'h0, hit, sidx}, {27'h0, h, i});
		@(posedge ref_clk);
		sua <= 1'b0;
	endtask

	initial begin
		logic [7:0] io_a;
		{cyc, stb, we, fast, sua, conv_s, conv_d} = '0;
		{adr, sel, dat_i, saddr, ext, pirq, sysirq} = '0;
		errors = 0;
		checks = 0;
		rst = 1'b1;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		tick(1);
		rchk(REG_CHIP_ID, CHIP_ID_BASE | {30'h0, MEM_VARIANT});
		bus(1'b1, REG_CHIP_ID, 32'h0000_0000);
		rchk(REG_CHIP_ID, CHIP_ID_BASE | {30'h0, MEM_VARIANT});
		rchk(8'h54, 32'h0000_0000);
		rchk(REG_CLK_STATUS, CLK_RESET);
		bus(1'b1, REG_CLK_SET, 32'hFFFF_FFFF);
		rchk(REG_CLK_STATUS, CLK_WRITABLE_MASK | CLK_RESET);
		for (int n = 0; n < IO_COUNT; n++) begin
			io_a = IO_BASE + 8'(16 * n);
			cmp(psel[n], IO_RESET_PERIPH[n]);
			rchk(io_a + {4'h0, IO_SEL_OFS}, IO_RESET_PERIPH[n]);
			rchk(io_a + {4'h0, IO_PULL_OFS}, IO_RESET_PULLUP);
			cmp(pull[n], IO_RESET_PULLUP);
			rchk(io_a + {4'h0, IO_AB_OFS}, IO_RESET_AB);
			bus(1'b1, io_a + {4'h0, IO_AB_OFS}, 32'hA5A5_0F0F ^ 32'(n));
			rchk(io_a + {4'h0, IO_AB_OFS}, 32'hA5A5_0F0F ^ 32'(n));
			cmp(bsel[n], 32'hA5A5_0F0F ^ 32'(n));
		end
		// Converter clock starts on the first conversion and stops after a conversion in sleep
		bus(1'b1, REG_EVT_ENABLE, 32'h0000_0007);
		@(posedge ref_clk);
		conv_s <= 1'b1;
		@(posedge ref_clk);
		conv_s <= 1'b0;
		tick(2);
		cmp(clk_en, CLK_WRITABLE_MASK | 32'h0000_0022);
		cmp({31'h0, eirq}, 32'h0000_0001);
		bus(1'b1, REG_CLK_CLEAR, 32'hFFFF_FFFF);
		rchk(REG_CLK_STATUS, 32'h0000_0022);
		rchk(REG_EVT_STATUS, 32'h0000_0001);
		bus(1'b1, REG_EVT_CLEAR, 32'h0000_0007);
		tick(2);
		cmp({31'h0, eirq}, 32'h0000_0000);
		bus(1'b1, REG_MODE, 32'h0000_0001);
		@(posedge ref_clk);
		conv_d <= 1'b1;
		@(posedge ref_clk);
		conv_d <= 1'b0;
		tick(2);
		rchk(REG_CLK_STATUS, CLK_RESET);
		rchk(REG_EVT_STATUS, 32'h0000_0002);
		bus(1'b1, REG_EVT_ENABLE, 32'h0000_0000);
		tick(2);
		cmp({31'h0, eirq}, 32'h0000_0000);
		bus(1'b1, REG_EVT_CLEAR, 32'h0000_0007);
		// Slot decode edges of the range
		slot(32'hFFFA_0000, 1'b1, 4'h0);
		slot(32'hFFFA_4000, 1'b1, 4'h1);
		slot(32'hFFFA_3FFF, 1'b1, 4'h0);
		slot(32'hFFFC_FFFF, 1'b1, 4'hB);
		slot(32'hFFF9_FFFF, 1'b0, 4'h0);
		slot(32'hFFFD_0000, 1'b0, 4'h0);
		tick(2);
		rchk(REG_EVT_STATUS, 32'h0000_0004);
		// Interrupt routing by identifier
		@(posedge ref_clk);
		fast <= 1'b1;
		ext <= 3'h5;
		pirq <= '1;
		tick(6);
		cmp(src, PERIPH_IRQ_MASK | 32'hA000_0001);
		@(posedge ref_clk);
		{fast, pirq} <= '0;
		ext <= 3'h2;
		tick(6);
		cmp(src, 32'h4000_0000);
		@(posedge ref_clk);
		ext <= 3'h0;
		for (int i = 0; i < SYS_SRC_COUNT; i++) begin
			@(posedge ref_clk);
			sysirq <= 8'(1 << i);
			tick(2);
			cmp(src, 32'h0000_0002);
		end
		@(posedge ref_clk);
		sysirq <= 8'h00;
		tick(2);
		cmp(src, 32'h0000_0000);
		cmp(pend, 32'hFFFE_7FFF);
		cmp(clks & CLK_FIXED_MASK, CLK_RESET);
		end_sim();
	end
endmodule
`default_nettype wire
